// *** pkg/pfltc_pkg.sv ***
// Constants, offsets and field layouts of the fault and trigger control block
package pfltc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // ==========================================================
    // Register offsets
    localparam logic [3:0] OFS_FCL = 4'h0;
    localparam logic [3:0] OFS_TRIG = 4'h1;
    localparam logic [3:0] OFS_LEB = 4'h2;
    localparam logic [3:0] OFS_CTRL = 4'h3;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h6;

    // ==========================================================
    // Writable bits and reset values
    localparam logic [15:0] FCL_WMASK = 16'h1FFF;
    localparam logic [15:0] TRIG_WMASK = 16'hFFF8;
    localparam logic [15:0] LEB_WMASK = 16'hFFF8;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] TRIG_OFF = 16'h0000;
    localparam logic [15:0] TRIG_MIN = 16'h0008;

    // ==========================================================
    // Fault limit control fields
    localparam int FCL_MODE_LO = 0;
    localparam int FCL_POL = 2;
    localparam int FCL_SRC_LO = 3;

    // Fault response modes
    localparam logic [1:0] MODE_LATCH = 2'h0;
    localparam logic [1:0] MODE_CYCLE = 2'h1;
    localparam logic [1:0] MODE_OFF = 2'h3;

    // Codes that name a real source
    localparam logic [15:0] SRC_VALID = 16'hAF0F;
    localparam logic [3:0] SRC_CMP1 = 4'h0;
    localparam logic [3:0] SRC_SH1 = 4'h8;
    localparam logic [3:0] SRC_SH3 = 4'hA;
    localparam logic [3:0] SRC_IND2 = 4'hD;
    localparam logic [3:0] SRC_IND4 = 4'hF;

    // ==========================================================
    // Edge blanking fields
    localparam int LEB_INT_LO = 3;
    localparam int LEB_INT_W = 7;
    localparam int LEB_CL_EN = 10;
    localparam int LEB_FLT_EN = 11;
    localparam int LEB_LF = 12;
    localparam int LEB_LR = 13;
    localparam int LEB_HF = 14;
    localparam int LEB_HR = 15;

    // ==========================================================
    // Control, status and interrupt fields
    localparam int CTRL_OVR_LO = 0;
    localparam int CTRL_CLR = 8;
    localparam int IRQ_TRIG = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_W = 2;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int LEB_STEP_NS = 8;
    localparam int LEB_STEP_CYC = (LEB_STEP_NS / CLK_PERIOD_NS) < 1 ? 1
                                  : (LEB_STEP_NS / CLK_PERIOD_NS);
    localparam int BLANK_W = 9;

    // Width of the synchronised pin bundle
    localparam int PIN_W = 11;

endpackage : pfltc_pkg

// *** verilog/pfltc_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous pins
module pfltc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Pins and synchronised copy
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // Both stages; only the second stage is visible
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pfltc_sync

// *** verilog/pfltc_top.sv ***
// Fault selection, override, edge blanking and trigger logic of one channel
// Operation
// - Source codes 0-3 pick comparators 1-4; codes 4-7 select nothing.
// - Codes 8, 9, 10 and 11 pick shared fault inputs 1, 2, 3 and 4.
// - Codes 13 and 15 pick independent faults 2 and 4; 12, 14 nothing.
// - Polarity one means the source is active low, zero active high.
// - Mode 0 forces both outputs to override values and latches it.
// - Mode 1 forces both outputs to override values until next cycle.
// - Mode 3 ignores the fault; mode 2 is reserved.
// - Trigger compare value sits in bits 15:3, compared to the time base.
// - A time base match fires the converter start and trigger interrupt.
// - A compare value of zero never fires a trigger.
// - Trigger compare bits 2:0 read as zero.
// - Blanking interval counts in steps of eight nanoseconds.
// - Current-limit blanking enable clear leaves that input unblanked.
//
// Local design decisions: the plain strobed port and the address map.
module pfltc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [pfltc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pfltc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pfltc_pkg::DATA_W-1:0] reg_rdata,
    // Fault and current-limit pins
    input wire logic [3:0] comparator_in,
    input wire logic [3:0] shared_fault_in,
    input wire logic independent_fault_in_2,
    input wire logic independent_fault_in_4,
    input wire logic current_limit_in,
    // PWM generator side
    input wire logic pwm_high_in,
    input wire logic pwm_low_in,
    input wire logic cycle_start,
    input wire logic [15:0] time_base,
    // Outputs
    output logic pwm_high_output,
    output logic pwm_low_output,
    output logic current_limit_blanked,
    output logic adc_trigger,
    output logic irq
);
    import pfltc_pkg::*;

    // ==========================================================
    // Registers
    logic [15:0] fault_limit_control_reg;
    logic [15:0] trigger_compare_reg;
    logic [15:0] edge_blanking_control_reg;
    logic [1:0] fault_override_value_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic latch_reg;
    logic latch_next;
    logic cycle_reg;
    logic cycle_next;
    logic [BLANK_W-1:0] blank_cnt_reg;
    logic pwm_high_prev_reg;
    logic pwm_low_prev_reg;
    logic hit_prev_reg;

    // ==========================================================
    // Pin synchroniser
    logic [PIN_W-1:0] pins_sync;
    pfltc_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({current_limit_in, independent_fault_in_4, independent_fault_in_2,
                   shared_fault_in, comparator_in}),
        .sync_out(pins_sync)
    );

    // ==========================================================
    // Field decode
    wire [1:0] fault_response_mode = fault_limit_control_reg[FCL_MODE_LO +: 2];
    wire fault_polarity = fault_limit_control_reg[FCL_POL];
    wire [3:0] fault_source_select = fault_limit_control_reg[FCL_SRC_LO +: 4];
    wire [12:0] trigger_compare_value = trigger_compare_reg[15:3];
    wire [LEB_INT_W-1:0] blanking_interval = edge_blanking_control_reg[LEB_INT_LO +: LEB_INT_W];
    wire fault_blanking_enable = edge_blanking_control_reg[LEB_FLT_EN];
    wire current_limit_blanking_enable = edge_blanking_control_reg[LEB_CL_EN];
    wire high_rise_blank_trigger = edge_blanking_control_reg[LEB_HR];
    wire high_fall_blank_trigger = edge_blanking_control_reg[LEB_HF];
    wire low_rise_blank_trigger = edge_blanking_control_reg[LEB_LR];
    wire low_fall_blank_trigger = edge_blanking_control_reg[LEB_LF];

    // ==========================================================
    // Fault source selection
    wire [3:0] cmp_sync = pins_sync[3:0];
    wire [3:0] shared_sync = pins_sync[7:4];
    wire ind2_sync = pins_sync[8];
    wire ind4_sync = pins_sync[9];
    wire cl_sync = pins_sync[10];
    wire [15:0] src_vec = {ind4_sync, 1'b0, ind2_sync, 1'b0,
                           shared_sync[3:0],
                           4'h0, cmp_sync[3:0]};
    wire fault_raw = src_vec[fault_source_select];
    wire src_ok = SRC_VALID[fault_source_select];
    // Polarity first, then blanking and mode logic
    wire fault_asserted = src_ok & (fault_raw ^ fault_polarity);

    // ==========================================================
    // Leading-edge blanking
    wire blank_start = (high_rise_blank_trigger & pwm_high_in & ~pwm_high_prev_reg)
                     | (high_fall_blank_trigger & ~pwm_high_in & pwm_high_prev_reg)
                     | (low_rise_blank_trigger & pwm_low_in & ~pwm_low_prev_reg)
                     | (low_fall_blank_trigger & ~pwm_low_in & pwm_low_prev_reg);
    wire [BLANK_W-1:0] blank_load = BLANK_W'(blanking_interval * LEB_STEP_CYC);
    wire blank_active = blank_cnt_reg != '0;
    wire fault_eff = fault_asserted & ~(fault_blanking_enable & blank_active);
    wire cl_eff = cl_sync & ~(current_limit_blanking_enable & blank_active);

    // ==========================================================
    // Fault response
    wire mode_latch = fault_response_mode == MODE_LATCH;
    wire mode_cycle = fault_response_mode == MODE_CYCLE;
    wire latch_clr = reg_wr & (reg_addr == OFS_CTRL) & reg_wdata[CTRL_CLR];
    wire override = (latch_reg & mode_latch) | (cycle_reg & mode_cycle);
    wire fault_event = fault_eff & (mode_latch | mode_cycle);

    // Latch set wins over a software clear
    assign latch_next = (fault_eff & mode_latch) | (latch_reg & ~latch_clr);
    // Cycle hold set wins over the cycle boundary
    assign cycle_next = (fault_eff & mode_cycle) | (cycle_reg & ~cycle_start);

    // ==========================================================
    // Trigger compare
    wire trig_hit = (trigger_compare_reg != TRIG_OFF)
                  & (time_base == {trigger_compare_value, 3'h0});
    wire trig_fire = trig_hit & ~hit_prev_reg;

    // ==========================================================
    // Register decode
    wire wr_fcl = reg_wr & (reg_addr == OFS_FCL);
    wire wr_trig = reg_wr & (reg_addr == OFS_TRIG);
    wire wr_leb = reg_wr & (reg_addr == OFS_LEB);
    wire wr_ctrl = reg_wr & (reg_addr == OFS_CTRL);
    wire wr_mask = reg_wr & (reg_addr == OFS_IRQ_MASK);
    wire rd_istat = reg_rd & (reg_addr == OFS_IRQ_STAT);
    wire [IRQ_W-1:0] irq_set = {fault_event, trig_fire};
    wire [15:0] stat_word = {13'h0, fault_asserted, cycle_reg, latch_reg};
    wire [15:0] rd_mux =
        (reg_addr == OFS_FCL) ? fault_limit_control_reg :
        (reg_addr == OFS_TRIG) ? (trigger_compare_reg & TRIG_WMASK) :
        (reg_addr == OFS_LEB) ? edge_blanking_control_reg :
        (reg_addr == OFS_CTRL) ? {14'h0, fault_override_value_reg} :
        (reg_addr == OFS_STAT) ? stat_word :
        (reg_addr == OFS_IRQ_STAT) ? {14'h0, irq_stat_reg} :
        (reg_addr == OFS_IRQ_MASK) ? {14'h0, irq_mask_reg} : 16'h0000;

    // Sticky events; a new event wins over the read clear
    assign irq_stat_next = irq_set | (irq_stat_reg & ~{IRQ_W{rd_istat}});

    // ==========================================================
    // Software registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fault_limit_control_reg <= REG_RESET;
            trigger_compare_reg <= REG_RESET;
            edge_blanking_control_reg <= REG_RESET;
            fault_override_value_reg <= 2'h0;
            irq_mask_reg <= '0;
        end else begin
            if (wr_fcl) fault_limit_control_reg <= reg_wdata & FCL_WMASK;
            if (wr_trig) trigger_compare_reg <= reg_wdata & TRIG_WMASK;
            if (wr_leb) edge_blanking_control_reg <= reg_wdata & LEB_WMASK;
            if (wr_ctrl) fault_override_value_reg <= reg_wdata[CTRL_OVR_LO +: 2];
            if (wr_mask) irq_mask_reg <= reg_wdata[IRQ_W-1:0];
        end
    end

    // Fault state, blanking counter and edge history
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch_reg <= 1'b0;
            cycle_reg <= 1'b0;
            blank_cnt_reg <= '0;
            pwm_high_prev_reg <= 1'b0;
            pwm_low_prev_reg <= 1'b0;
            hit_prev_reg <= 1'b0;
            irq_stat_reg <= '0;
        end else begin
            latch_reg <= latch_next;
            cycle_reg <= cycle_next;
            if (blank_start) begin
                blank_cnt_reg <= blank_load;
            end else if (blank_active) begin
                blank_cnt_reg <= blank_cnt_reg - 1'b1;
            end
            pwm_high_prev_reg <= pwm_high_in;
            pwm_low_prev_reg <= pwm_low_in;
            hit_prev_reg <= trig_hit;
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwm_high_output <= 1'b0;
            pwm_low_output <= 1'b0;
            current_limit_blanked <= 1'b0;
            adc_trigger <= 1'b0;
            irq <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            pwm_high_output <= override ? fault_override_value_reg[1] : pwm_high_in;
            pwm_low_output <= override ? fault_override_value_reg[0] : pwm_low_in;
            current_limit_blanked <= cl_eff;
            adc_trigger <= trig_fire;
            irq <= |(irq_stat_next & irq_mask_reg);
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // ==========================================================
    // Assertions
    sequence s_fault_latched;
        mode_latch && fault_eff ##1 latch_reg;
    endsequence

    AST_SRC_COMP: assert property (@(posedge ref_clk) disable iff (rst)
        fault_source_select <= 4'h3 |-> fault_raw == cmp_sync[fault_source_select[1:0]])
        else $error("comparator source not routed");
    AST_SRC_RSV: assert property (@(posedge ref_clk) disable iff (rst)
        fault_source_select[3:2] == 2'h1 |-> !fault_asserted)
        else $error("reserved source produced a fault");
    AST_SRC_SHARED: assert property (@(posedge ref_clk) disable iff (rst)
        fault_source_select == SRC_SH1 |-> fault_raw == shared_sync[0])
        else $error("shared fault 1 not routed");
    AST_SRC_SH3: assert property (@(posedge ref_clk) disable iff (rst)
        fault_source_select == SRC_SH3 |-> fault_raw == shared_sync[2])
        else $error("shared fault 3 not routed");
    AST_SRC_IND: assert property (@(posedge ref_clk) disable iff (rst)
        (fault_source_select == SRC_IND2 |-> fault_raw == ind2_sync) and
        (fault_source_select == SRC_IND4 |-> fault_raw == ind4_sync))
        else $error("independent fault not routed");
    AST_POL: assert property (@(posedge ref_clk) disable iff (rst)
        src_ok |-> fault_asserted == (fault_polarity ? !fault_raw : fault_raw))
        else $error("fault polarity wrong");
    AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        s_fault_latched ##0 (mode_latch && !latch_clr)[*2] |=>
            pwm_high_output == fault_override_value_reg[1])
        else $error("latched override not held");
    AST_CYCLE_END: assert property (@(posedge ref_clk) disable iff (rst)
        cycle_reg && cycle_start && !(fault_eff && mode_cycle) |=> !cycle_reg)
        else $error("cycle override outlived its cycle");
    AST_MODE_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        fault_response_mode == MODE_OFF |=> pwm_low_output == $past(pwm_low_in))
        else $error("disabled fault touched output");
    AST_TRIG_FIRE: assert property (@(posedge ref_clk) disable iff (rst)
        trig_hit && !hit_prev_reg |=> adc_trigger && irq_stat_reg[IRQ_TRIG])
        else $error("match gave no trigger");
    AST_TRIG_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
        trigger_compare_reg == TRIG_OFF |=> !adc_trigger)
        else $error("zero compare fired");
    AST_TRIG_LOW: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_TRIG |=> reg_rdata[2:0] == 3'h0)
        else $error("trigger low bits not zero");
    AST_BLANK_LEN: assert property (@(posedge ref_clk) disable iff (rst)
        blank_start |=> blank_cnt_reg == $past(blank_load))
        else $error("blanking length wrong");
    AST_CL_NOBLANK: assert property (@(posedge ref_clk) disable iff (rst)
        !current_limit_blanking_enable |=> current_limit_blanked == $past(cl_sync))
        else $error("current limit blanked while disabled");
    // Further routing, state and counter checks
    AST_SRC_SH_ALL: assert property (@(posedge ref_clk) disable iff (rst)
        fault_source_select[3:2] == 2'h2 |-> fault_raw == shared_sync[fault_source_select[1:0]])
        else $error("shared source not routed");
    AST_LATCH_SET: assert property (@(posedge ref_clk) disable iff (rst)
        mode_latch && fault_eff |=> latch_reg)
        else $error("fault not latched");
    AST_LATCH_CLR: assert property (@(posedge ref_clk) disable iff (rst)
        latch_reg && latch_clr && !(mode_latch && fault_eff) |=> !latch_reg)
        else $error("latch survived its clear");
    AST_CYCLE_FORCE: assert property (@(posedge ref_clk) disable iff (rst)
        cycle_reg && mode_cycle |=> pwm_low_output == $past(fault_override_value_reg[0]))
        else $error("cycle override not applied");
    AST_MODE_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
        fault_response_mode[1] |-> !fault_event && !override)
        else $error("idle fault mode acted");
    AST_PASS_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
        !override |=> pwm_high_output == $past(pwm_high_in))
        else $error("high output not passed through");
    AST_TRIG_ONCE: assert property (@(posedge ref_clk) disable iff (rst)
        hit_prev_reg |=> !adc_trigger)
        else $error("held match fired again");
    AST_TRIG_STORE: assert property (@(posedge ref_clk) disable iff (rst)
        wr_trig |=> trigger_compare_value == $past(reg_wdata[15:3]))
        else $error("compare value not stored");
    AST_BLANK_RUN: assert property (@(posedge ref_clk) disable iff (rst)
        blank_active && !blank_start |=> blank_cnt_reg == $past(blank_cnt_reg) - 1'b1)
        else $error("blanking counter skipped");
    AST_FLT_BLANK: assert property (@(posedge ref_clk) disable iff (rst)
        fault_blanking_enable && blank_active |-> !fault_eff)
        else $error("fault passed during blanking");

endmodule : pfltc_top

// *** dv/pfltc_fault_pins.sv ***
// Model of the fault pins and current-limit sense seen by the channel
module pfltc_fault_pins (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Levels asked for by the bench
    input wire logic [9:0] want_pins,
    input wire logic want_cl,
    input wire logic slow,
    // Pin drive
    output logic [3:0] comparator_in,
    output logic [3:0] shared_fault_in,
    output logic independent_fault_in_2,
    output logic independent_fault_in_4,
    output logic current_limit_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] stage_reg, pins_reg;
    // Pins settle one or two cycles after a request, like a slow comparator
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage_reg <= 11'h000;
            pins_reg <= 11'h000;
        end else begin
            stage_reg <= {want_cl, want_pins};
            pins_reg <= slow ? stage_reg : {want_cl, want_pins};
        end
    end
    // Pin bundle order: comparators, shared, independent, current limit
    assign {current_limit_in, independent_fault_in_4, independent_fault_in_2,
            shared_fault_in, comparator_in} = pins_reg;
endmodule : pfltc_fault_pins

// *** dv/pwm_fault_trigger_control_test.sv ***
// Self-checking bench of the fault and trigger control block
module pwm_fault_trigger_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pfltc_pkg::*;
    typedef struct packed {logic [15:0] mask; logic [15:0] val;} pfltc_exp_t;
    // ==========================================================
    // Stimulus, results and bookkeeping
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [9:0] want_pins = 10'h000;
    logic want_cl = 1'b0;
    logic slow = 1'b0;
    logic pwm_high_in = 1'b0;
    logic pwm_low_in = 1'b1;
    logic cycle_start = 1'b0;
    logic [15:0] time_base = 16'h0000;
    logic obs_req = 1'b0;
    logic rd_seen = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [3:0] comparator_in, shared_fault_in;
    logic independent_fault_in_2, independent_fault_in_4, current_limit_in;
    logic pwm_high_output, pwm_low_output, current_limit_blanked, adc_trigger, irq;
    logic [15:0] seed = 16'h004F;
    logic [9:0] pins;
    pfltc_exp_t rd_q[$], obs_q[$];
    int err_count = 0;
    int samples_checked = 0;

    // Clock at 4 ns
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    pfltc_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .comparator_in(comparator_in), .shared_fault_in(shared_fault_in),
        .independent_fault_in_2(independent_fault_in_2),
        .independent_fault_in_4(independent_fault_in_4),
        .current_limit_in(current_limit_in), .pwm_high_in(pwm_high_in),
        .pwm_low_in(pwm_low_in), .cycle_start(cycle_start), .time_base(time_base),
        .pwm_high_output(pwm_high_output), .pwm_low_output(pwm_low_output),
        .current_limit_blanked(current_limit_blanked), .adc_trigger(adc_trigger),
        .irq(irq));
    pfltc_fault_pins i_pins (.ref_clk(ref_clk), .rst(rst), .want_pins(want_pins),
        .want_cl(want_cl), .slow(slow), .comparator_in(comparator_in),
        .shared_fault_in(shared_fault_in), .independent_fault_in_2(independent_fault_in_2),
        .independent_fault_in_4(independent_fault_in_4), .current_limit_in(current_limit_in));

    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // Pin that a source code should pick, none for reserved codes
    function automatic logic [9:0] src_pin(input logic [3:0] c);
        case (c)
            4'h0, 4'h1, 4'h2, 4'h3: return 10'h001 << c;
            4'h8, 4'h9, 4'hA, 4'hB: return 10'h010 << (c - 4'h8);
            4'hD: return 10'h100;
            4'hF: return 10'h200;
            default: return 10'h000;
        endcase
    endfunction : src_pin
    task automatic check(input logic [15:0] seen, input pfltc_exp_t e);
        samples_checked++;
        if ((seen & e.mask) !== (e.val & e.mask)) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen & e.mask,
                     e.val & e.mask);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] v, input logic [15:0] m);
        rd_q.push_back('{m, v});
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
    endtask : rd
    // Output bits: irq, trigger, blanked limit, high, low
    task automatic obs(input logic [4:0] v, input logic [4:0] m);
        obs_q.push_back('{{11'h000, m}, {11'h000, v}});
        obs_req <= 1'b1;
        tick(1);
        obs_req <= 1'b0;
    endtask : obs
    task automatic pulse();
        cycle_start <= 1'b1;
        tick(1);
        cycle_start <= 1'b0;
        tick(1);
    endtask : pulse
    task automatic done_test(input string name);
        $display("test %s finished", name);
    endtask : done_test
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // Monitor takes the oldest note for each result
    always @(posedge ref_clk) begin
        if (rd_seen) begin
            check(reg_rdata, rd_q.pop_front());
        end
        if (obs_req) begin
            check({11'h000, irq, adc_trigger, current_limit_blanked, pwm_high_output,
                   pwm_low_output}, obs_q.pop_front());
        end
        rd_seen <= reg_rd;
    end

    // Watchdog against a hung run
    initial begin
        tick(6000);
        err_count++;
        give_verdict();
    end

    // Main sequence
    initial begin
        tick(2);
        rst <= 1'b0;
        tick(1);
        for (int a = 0; a < 8; a++) begin
            rd(a[3:0], REG_RESET, 16'hFFFF);
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            wr(OFS_TRIG, seed);
            rd(OFS_TRIG, seed & TRIG_WMASK, 16'hFFFF);
            wr(OFS_LEB, ~seed);
            rd(OFS_LEB, ~seed & LEB_WMASK, 16'hFFFF);
        end
        wr(OFS_FCL, 16'hFFFF);
        rd(OFS_FCL, FCL_WMASK, 16'hFFFF);
        wr(4'h7, 16'hFFFF);
        rd(4'h7, 16'h0000, 16'hFFFF);
        done_test("registers");
        wr(OFS_LEB, 16'h0000);
        wr(OFS_IRQ_MASK, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_TRIG, k == 0 ? 16'h0010 : TRIG_OFF);
            for (int t = 0; t < 24; t++) begin
                time_base <= t[15:0];
                tick(1);
                obs({1'b0, k == 0 && t == 16, 3'h0}, 5'h08);
            end
            if (k == 0) begin
                tick(1);
                obs(5'h10, 5'h10);
                rd(OFS_IRQ_STAT, 16'h0001, 16'hFFFF);
                tick(1);
                obs(5'h00, 5'h10);
            end
        end
        done_test("trigger");
        wr(OFS_CTRL, 16'h0002);
        for (int c = 0; c < 16; c++) begin
            pins = src_pin(c[3:0]);
            slow <= c[0];
            wr(OFS_FCL, {9'h000, c[3:0], 3'h1});
            want_pins <= (pins == 10'h000) ? 10'h3FF : pins;
            tick(6);
            obs(pins == 10'h000 ? 5'h01 : 5'h02, 5'h03);
            want_pins <= 10'h000;
            tick(6);
            pulse();
            tick(6);
        end
        wr(OFS_FCL, 16'h0005);
        want_pins <= 10'h3FE;
        tick(6);
        obs(5'h02, 5'h03);
        want_pins <= 10'h3FF;
        tick(6);
        pulse();
        tick(6);
        obs(5'h01, 5'h03);
        wr(OFS_FCL, 16'h0003);
        want_pins <= 10'h000;
        tick(6);
        done_test("sources");
        wr(OFS_FCL, 16'h0001);
        want_pins <= 10'h001;
        tick(6);
        obs(5'h02, 5'h03);
        want_pins <= 10'h000;
        tick(8);
        obs(5'h02, 5'h03);
        pulse();
        tick(3);
        obs(5'h01, 5'h03);
        for (int m = 2; m < 4; m++) begin
            wr(OFS_FCL, {14'h0000, m[1:0]});
            want_pins <= 10'h001;
            tick(6);
            obs(5'h01, 5'h03);
            want_pins <= 10'h000;
            tick(6);
        end
        wr(OFS_IRQ_MASK, 16'h0002);
        rd(OFS_IRQ_STAT, 16'h0002, 16'h0002);
        wr(OFS_FCL, 16'h0000);
        obs(5'h01, 5'h13);
        want_pins <= 10'h001;
        tick(6);
        want_pins <= 10'h000;
        tick(6);
        pulse();
        tick(3);
        obs(5'h12, 5'h13);
        rd(OFS_STAT, 16'h0001, 16'h0005);
        rd(OFS_IRQ_STAT, 16'h0002, 16'h0002);
        wr(OFS_CTRL, 16'h0102);
        tick(3);
        obs(5'h01, 5'h13);
        done_test("modes");
        want_cl <= 1'b1;
        wr(OFS_LEB, 16'h8420);
        tick(6);
        pwm_high_in <= 1'b1;
        tick(6);
        obs(5'h00, 5'h04);
        tick(10);
        obs(5'h04, 5'h04);
        wr(OFS_LEB, 16'h8020);
        pwm_high_in <= 1'b0;
        tick(2);
        pwm_high_in <= 1'b1;
        tick(2);
        obs(5'h04, 5'h04);
        done_test("blanking");
        tick(4);
        give_verdict();
    end
endmodule : pwm_fault_trigger_control_test
